// ---- rtl/comm_port_status_flag_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
// serial port status flag bank behind an apb slave
module comm_port_status_flag_bank
import cps_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    // apb slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [CPS_ADDR_W-1:0]  paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output var  logic [31:0]            prdata_out,
    output var  logic                   pready_out,
    output var  logic                   pslverr_out,
    output var  logic                   irq_out,
    // controller scan and execution state
    input  wire logic                   scan_start_in,
    input  wire logic                   rewrite_done_in,
    input  wire logic                   print_busy_in,
    input  wire logic [CPS_NUM_HSC-1:0] hsc_busy_in,
    input  wire logic                   interp_busy_in,
    input  wire logic                   interp_data_take_in,
    output var  logic                   interp_load_out,
    // port protocol selection
    input  wire cps_proto_t             first_port_proto_in,
    input  wire cps_proto_t             second_port_proto_in,
    input  wire logic                   tool_port_gp_in,
    // general-purpose serial events, one bit per port
    input  wire logic [CPS_NUM_PORTS-1:0] term_rx_in,
    input  wire logic [CPS_NUM_PORTS-1:0] rx_rearm_in,
    input  wire logic [CPS_NUM_PORTS-1:0] tx_req_in,
    input  wire logic [CPS_NUM_PORTS-1:0] tx_done_in,
    input  wire logic [CPS_NUM_PORTS-1:0] tx_err_in,
    // remote send/receive, bit 0 first port, bit 1 second port
    input  wire logic [1:0]             sr_start_in,
    input  wire logic [1:0]             sr_done_in,
    input  wire logic [1:0]             sr_fail_in,
    input  wire logic [CPS_CODE_W-1:0]  first_end_code_in,
    input  wire logic [CPS_CODE_W-1:0]  second_end_code_in,
    input  wire logic [CPS_CODE_W-1:0]  link_error_code_in
);
    // mode and execution flags
    logic                     first_port_mode_flag;
    logic                     second_port_mode_flag;
    logic                     tool_port_mode_flag;
    logic                     first_port_peer_link_flag;
    logic                     print_exec_flag;
    logic                     circular_interp_active_flag;
    logic [CPS_NUM_HSC-1:0]   hsc_flag;
    logic                     next_first_mode;
    logic                     next_second_mode;
    logic                     next_tool_mode;
    logic                     next_peer;
    logic                     next_print;
    logic                     next_interp_act;
    logic [CPS_NUM_HSC-1:0]   next_hsc;
    // rewrite-done scan pulse
    logic                     run_rewrite_done_flag;
    logic                     rewrite_pending;
    logic                     next_rewrite_flag;
    logic                     next_rewrite_pending;
    // interpolation data handshake
    logic                     next_interp_load;
    // shared error code word
    logic [CPS_CODE_W-1:0]    link_error_code_word;
    logic [CPS_CODE_W-1:0]    next_error_code;
    // per-port flag outputs
    logic [CPS_NUM_PORTS-1:0] gp_mode;
    logic [CPS_NUM_PORTS-1:0] rx_done;
    logic [CPS_NUM_PORTS-1:0] tx_done;
    logic [CPS_NUM_PORTS-1:0] port_err;
    logic [1:0]               sr_ready;
    logic [1:0]               sr_result;
    logic [CPS_CODE_W-1:0]    first_port_end_code_word;
    logic [CPS_CODE_W-1:0]    second_port_end_code_word;
    // assembled words
    logic [CPS_WORD_W-1:0]    port_status_word_low;
    logic [CPS_WORD_W-1:0]    port_status_word_high;
    logic [31:0]              flags_now;
    // interrupt state
    logic [31:0]              flags_prev;
    logic [31:0]              irq_status;
    logic [31:0]              irq_mask;
    logic [31:0]              next_irq_status;
    logic [31:0]              next_irq_mask;
    logic                     next_irq;
    // apb state
    cps_apb_state_t           apb_state;
    cps_apb_state_t           next_apb_state;
    logic                     next_pready;
    logic                     next_pslverr;
    logic [31:0]              next_prdata;
    logic [31:0]              rd_data;
    logic                     rd_err;
    logic                     wr_fire;

    // mode flags follow the selected protocol in any cycle
    always_comb
    begin
        next_first_mode  = (first_port_proto_in == CPS_PROTO_GP);
        next_second_mode = (second_port_proto_in == CPS_PROTO_GP);
        next_tool_mode   = tool_port_gp_in;
        next_peer        = (first_port_proto_in == CPS_PROTO_LINK);
        next_print       = print_busy_in;
        next_interp_act  = interp_busy_in;
        next_hsc         = hsc_busy_in;
    end

    // mode and execution flag registers
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            first_port_mode_flag        <= 1'b0;
            second_port_mode_flag       <= 1'b0;
            tool_port_mode_flag         <= 1'b0;
            first_port_peer_link_flag   <= 1'b0;
            print_exec_flag             <= 1'b0;
            circular_interp_active_flag <= 1'b0;
            hsc_flag                    <= '0;
        end
        else
        begin
            first_port_mode_flag        <= next_first_mode;
            second_port_mode_flag       <= next_second_mode;
            tool_port_mode_flag         <= next_tool_mode;
            first_port_peer_link_flag   <= next_peer;
            print_exec_flag             <= next_print;
            circular_interp_active_flag <= next_interp_act;
            hsc_flag                    <= next_hsc;
        end
    end

    // a rewrite arms the flag; the next scan start shows it for that scan only
    always_comb
    begin
        next_rewrite_pending = rewrite_done_in | (rewrite_pending & ~scan_start_in);
        // completion in the same cycle as a scan start waits for the next scan
        next_rewrite_flag = scan_start_in ? rewrite_pending : run_rewrite_done_flag;
    end

    // rewrite registers
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rewrite_pending       <= 1'b0;
            run_rewrite_done_flag <= 1'b0;
        end
        else
        begin
            rewrite_pending       <= next_rewrite_pending;
            run_rewrite_done_flag <= next_rewrite_flag;
        end
    end

    // per-port general-purpose mode for the flag cells
    always_comb
    begin
        gp_mode                  = '0;
        gp_mode[CPS_PORT_FIRST]  = first_port_mode_flag;
        gp_mode[CPS_PORT_TOOL]   = tool_port_mode_flag;
        gp_mode[CPS_PORT_SECOND] = second_port_mode_flag;
    end

    // one flag cell per serial port
    genvar port_idx;
    generate
        for (port_idx = 0; port_idx < CPS_NUM_PORTS; port_idx++)
        begin : g_port
            cps_serial_port_flags u_flags
            (
                .clk_in      (clk_in),
                .reset_in    (reset_in),
                .gp_mode_in  (gp_mode[port_idx]),
                .term_rx_in  (term_rx_in[port_idx]),
                .rx_rearm_in (rx_rearm_in[port_idx]),
                .tx_req_in   (tx_req_in[port_idx]),
                .tx_done_in  (tx_done_in[port_idx]),
                .tx_err_in   (tx_err_in[port_idx]),
                .rx_done_out (rx_done[port_idx]),
                .tx_done_out (tx_done[port_idx]),
                .err_out     (port_err[port_idx])
            );
        end
    endgenerate

    // remote send/receive on the first port
    cps_remote_xfer_flags u_sr_first
    (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .start_in     (sr_start_in[0]),
        .done_in      (sr_done_in[0]),
        .fail_in      (sr_fail_in[0]),
        .end_code_in  (first_end_code_in),
        .ready_out    (sr_ready[0]),
        .result_out   (sr_result[0]),
        .end_code_out (first_port_end_code_word)
    );

    // remote send/receive on the second port
    cps_remote_xfer_flags u_sr_second
    (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .start_in     (sr_start_in[1]),
        .done_in      (sr_done_in[1]),
        .fail_in      (sr_fail_in[1]),
        .end_code_in  (second_end_code_in),
        .ready_out    (sr_ready[1]),
        .result_out   (sr_result[1]),
        .end_code_out (second_port_end_code_word)
    );

    // shared error code: any failing finish stores it, one word for both ports
    always_comb
    begin
        next_error_code = link_error_code_word;
        if (|(sr_done_in & sr_fail_in))
        begin
            next_error_code = link_error_code_in;
        end
    end

    // error code register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            link_error_code_word <= '0;
        end
        else
        begin
            link_error_code_word <= next_error_code;
        end
    end

    // assemble both flag words; unused positions stay zero
    always_comb
    begin
        port_status_word_low  = '0;
        port_status_word_high = '0;
        port_status_word_low[CPS_LO_FIRST_MODE] = first_port_mode_flag;
        port_status_word_low[CPS_LO_PRINT]      = print_exec_flag;
        port_status_word_low[CPS_LO_REWRITE]    = run_rewrite_done_flag;
        port_status_word_low[CPS_LO_FIRST_ERR]  = port_err[CPS_PORT_FIRST];
        port_status_word_low[CPS_LO_FIRST_RX]   = rx_done[CPS_PORT_FIRST];
        port_status_word_low[CPS_LO_FIRST_TX]   = tx_done[CPS_PORT_FIRST];
        port_status_word_low[CPS_LO_HSC0 +: CPS_NUM_HSC] = hsc_flag;
        port_status_word_low[CPS_LO_TOOL_RX]    = rx_done[CPS_PORT_TOOL];
        port_status_word_low[CPS_LO_TOOL_TX]    = tx_done[CPS_PORT_TOOL];
        port_status_word_high[CPS_HI_TOOL_MODE]   = tool_port_mode_flag;
        port_status_word_high[CPS_HI_PEER]        = first_port_peer_link_flag;
        port_status_word_high[CPS_HI_SECOND_MODE] = second_port_mode_flag;
        port_status_word_high[CPS_HI_SR1_READY]   = sr_ready[0];
        port_status_word_high[CPS_HI_SR1_RESULT]  = sr_result[0];
        port_status_word_high[CPS_HI_SECOND_ERR]  = port_err[CPS_PORT_SECOND];
        port_status_word_high[CPS_HI_SECOND_RX]   = rx_done[CPS_PORT_SECOND];
        port_status_word_high[CPS_HI_SECOND_TX]   = tx_done[CPS_PORT_SECOND];
        port_status_word_high[CPS_HI_SR2_READY]   = sr_ready[1];
        port_status_word_high[CPS_HI_SR2_RESULT]  = sr_result[1];
        port_status_word_high[CPS_HI_INTERP_ACT]  = circular_interp_active_flag;
        port_status_word_high[CPS_HI_INTERP_RLD]  = ~interp_load_out;
        flags_now = {port_status_word_high, port_status_word_low};
    end

    // a write is only taken at the edge where pready is seen high
    always_comb
    begin
        wr_fire = (apb_state == CPS_APB_DONE) & psel_in & penable_in & pwrite_in;
    end

    // new data is accepted only while the reload flag permits
    always_comb
    begin
        next_interp_load = interp_load_out & ~interp_data_take_in;
        if (wr_fire && paddr_in == CPS_ADDR_INTERP && !interp_load_out)
        begin
            next_interp_load = 1'b1;
        end
    end

    // interpolation handshake register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            interp_load_out <= 1'b0;
        end
        else
        begin
            interp_load_out <= next_interp_load;
        end
    end

    // rising flags set sticky status; a set beats a write-one clear
    always_comb
    begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (wr_fire && paddr_in == CPS_ADDR_IRQ_STAT)
        begin
            next_irq_status = irq_status & ~pwdata_in;
        end
        if (wr_fire && paddr_in == CPS_ADDR_IRQ_MASK)
        begin
            next_irq_mask = pwdata_in;
        end
        next_irq_status = next_irq_status | (flags_now & ~flags_prev);
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // interrupt registers; previous flags reset to the flag reset image
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            flags_prev <= {CPS_HI_RST, CPS_LO_RST};
            irq_status <= '0;
            irq_mask   <= CPS_MASK_RST;
            irq_out    <= 1'b0;
        end
        else
        begin
            flags_prev <= flags_now;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq_out    <= next_irq;
        end
    end

    // read mux and error decode; flag words ignore writes
    always_comb
    begin
        rd_data = '0;
        rd_err  = 1'b0;
        case (paddr_in)
            CPS_ADDR_WORD_LO:  rd_data = {16'h0000, port_status_word_low};
            CPS_ADDR_WORD_HI:  rd_data = {16'h0000, port_status_word_high};
            CPS_ADDR_IRQ_STAT: rd_data = irq_status;
            CPS_ADDR_IRQ_MASK: rd_data = irq_mask;
            CPS_ADDR_ERR_CODE: rd_data = {16'h0000, link_error_code_word};
            CPS_ADDR_END1:     rd_data = {16'h0000, first_port_end_code_word};
            CPS_ADDR_END2:     rd_data = {16'h0000, second_port_end_code_word};
            CPS_ADDR_INTERP:
            begin
                rd_data = {31'h0000_0000, interp_load_out};
                // refused while engine still holds unread data
                rd_err  = pwrite_in & interp_load_out;
            end
            default:           rd_err  = 1'b1;
        endcase
    end

    // one wait cycle: first access cycle decodes, second answers
    always_comb
    begin
        next_apb_state = CPS_APB_IDLE;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        next_prdata    = prdata_out;
        case (apb_state)
            CPS_APB_IDLE:
            begin
                if (psel_in && penable_in)
                begin
                    next_apb_state = CPS_APB_DONE;
                    next_pready    = 1'b1;
                    next_pslverr   = rd_err;
                    next_prdata    = pwrite_in ? 32'h0000_0000 : rd_data;
                end
            end
            CPS_APB_DONE:
            begin
                next_apb_state = CPS_APB_IDLE;
            end
            default:
            begin
                next_apb_state = CPS_APB_IDLE;
            end
        endcase
    end

    // apb registers
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            apb_state   <= CPS_APB_IDLE;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end
        else
        begin
            apb_state   <= next_apb_state;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out  <= next_prdata;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cps_pkg.sv ----
package cps_pkg;
    localparam int CPS_ADDR_W = 8;   // apb byte address width
    localparam int CPS_CODE_W = 16;  // error and end code words
    localparam int CPS_WORD_W = 16;  // flag word width
    // register byte addresses
    localparam logic [7:0] CPS_ADDR_WORD_LO  = 8'h00;
    localparam logic [7:0] CPS_ADDR_WORD_HI  = 8'h04;
    localparam logic [7:0] CPS_ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] CPS_ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] CPS_ADDR_ERR_CODE = 8'h10;
    localparam logic [7:0] CPS_ADDR_END1     = 8'h14;
    localparam logic [7:0] CPS_ADDR_END2     = 8'h18;
    localparam logic [7:0] CPS_ADDR_INTERP   = 8'h1c;
    // low word bit positions
    localparam int CPS_LO_FIRST_MODE = 2;
    localparam int CPS_LO_PRINT      = 3;
    localparam int CPS_LO_REWRITE    = 4;
    localparam int CPS_LO_FIRST_ERR  = 7;
    localparam int CPS_LO_FIRST_RX   = 8;
    localparam int CPS_LO_FIRST_TX   = 9;
    localparam int CPS_LO_HSC0       = 10;
    localparam int CPS_LO_TOOL_RX    = 14;
    localparam int CPS_LO_TOOL_TX    = 15;
    // high word bit positions
    localparam int CPS_HI_TOOL_MODE  = 0;
    localparam int CPS_HI_PEER       = 1;
    localparam int CPS_HI_SECOND_MODE = 2;
    localparam int CPS_HI_SR1_READY  = 4;
    localparam int CPS_HI_SR1_RESULT = 5;
    localparam int CPS_HI_SECOND_ERR = 7;
    localparam int CPS_HI_SECOND_RX  = 8;
    localparam int CPS_HI_SECOND_TX  = 9;
    localparam int CPS_HI_SR2_READY  = 10;
    localparam int CPS_HI_SR2_RESULT = 11;
    localparam int CPS_HI_INTERP_ACT = 14;
    localparam int CPS_HI_INTERP_RLD = 15;
    // serial port indices in the per-port vectors
    localparam int CPS_PORT_FIRST  = 0;
    localparam int CPS_PORT_TOOL   = 1;
    localparam int CPS_PORT_SECOND = 2;
    localparam int CPS_NUM_PORTS   = 3;
    localparam int CPS_NUM_HSC     = 4;
    // reset values
    localparam logic [15:0] CPS_LO_RST    = 16'h0000;
    localparam logic [15:0] CPS_HI_RST    = 16'h8410; // ready and reload high
    localparam logic [31:0] CPS_MASK_RST  = 32'h0000_0000;
    localparam logic        CPS_READY_RST = 1'b1;
    // port protocol selection
    typedef enum logic [1:0] {
        CPS_PROTO_GP     = 2'b00,
        CPS_PROTO_VENDOR = 2'b01,
        CPS_PROTO_LINK   = 2'b10
    } cps_proto_t;
    // apb answer state
    typedef enum logic {
        CPS_APB_IDLE = 1'b0,
        CPS_APB_DONE = 1'b1
    } cps_apb_state_t;
endpackage

// ---- rtl/cps_remote_xfer_flags.sv ----
`timescale 1ns/10ps
`default_nettype none
// ready, result and end code of remote send/receive on one port
module cps_remote_xfer_flags
import cps_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  start_in,    // send or receive started
    input  wire logic                  done_in,     // command finished
    input  wire logic                  fail_in,     // finished with comm error
    input  wire logic [CPS_CODE_W-1:0] end_code_in, // end code at finish
    output var  logic                  ready_out,
    output var  logic                  result_out,
    output var  logic [CPS_CODE_W-1:0] end_code_out
);
    logic                  next_ready;
    logic                  next_result;
    logic [CPS_CODE_W-1:0] next_end_code;

    // ready drops on start, returns on finish
    always_comb
    begin
        next_ready    = done_in | (ready_out & ~start_in);
        next_result   = done_in ? fail_in : result_out;
        next_end_code = done_in ? end_code_in : end_code_out;
    end

    // result registers
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ready_out    <= CPS_READY_RST;
            result_out   <= 1'b0;
            end_code_out <= '0;
        end
        else
        begin
            ready_out    <= next_ready;
            result_out   <= next_result;
            end_code_out <= next_end_code;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cps_serial_port_flags.sv ----
`timescale 1ns/10ps
`default_nettype none
// receive-done, transmit-done and error flags of one serial port
module cps_serial_port_flags
(
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic gp_mode_in,   // port in general-purpose serial
    input  wire logic term_rx_in,   // terminator character seen
    input  wire logic rx_rearm_in,  // receive buffer released
    input  wire logic tx_req_in,    // serial transmit command issued
    input  wire logic tx_done_in,   // transmission finished
    input  wire logic tx_err_in,    // transmission error
    output var  logic rx_done_out,
    output var  logic tx_done_out,
    output var  logic err_out
);
    logic next_rx_done;
    logic next_tx_done;
    logic next_err;

    // set terms come first so a set in the clearing cycle wins
    always_comb
    begin
        next_rx_done = (gp_mode_in & term_rx_in) | (rx_done_out & ~rx_rearm_in);
        next_tx_done = (gp_mode_in & tx_done_in) | (tx_done_out & ~tx_req_in);
        next_err     = tx_err_in | (err_out & ~tx_req_in);
    end

    // flag registers
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_done_out <= 1'b0;
            tx_done_out <= 1'b0;
            err_out     <= 1'b0;
        end
        else
        begin
            rx_done_out <= next_rx_done;
            tx_done_out <= next_tx_done;
            err_out     <= next_err;
        end
    end
endmodule
`default_nettype wire

// ---- sim/comm_port_status_flag_bank_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module comm_port_status_flag_bank_bench;
import cps_pkg::*;
    logic clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, errq;
    logic [7:0]  paddr_in = 0;
    logic [31:0] pwdata_in = 0, rdq;
    logic [10:0] lv = 11'h00a; // levels: print, counters, interp, protocols, tool
    logic [23:0] ev = 0; // event pulses packed in port order
    logic [15:0] first_end_code_in = 0, second_end_code_in = 0, link_error_code_in = 0;
    wire logic [31:0] prdata_out;
    wire logic pready_out, pslverr_out, irq_out, interp_load_out, print_busy_in;
    wire logic interp_busy_in, tool_port_gp_in, scan_start_in, rewrite_done_in;
    wire logic interp_data_take_in;
    wire logic [3:0] hsc_busy_in;
    wire logic [2:0] term_rx_in, rx_rearm_in, tx_req_in, tx_done_in, tx_err_in;
    wire logic [1:0] sr_start_in, sr_done_in, sr_fail_in;
    wire cps_proto_t first_port_proto_in = cps_proto_t'(lv[4:3]);
    wire cps_proto_t second_port_proto_in = cps_proto_t'(lv[2:1]);
    int error_cnt = 0, n_checks = 0;
    // levels beside the low and high words they give
    logic [42:0] rows [3] = '{{11'h402, 32'h8410_000c}, {11'h3f1, 32'hc417_3c00},
        {11'h14a, 32'h8410_1400}};
    assign {print_busy_in, hsc_busy_in, interp_busy_in, tool_port_gp_in} = {lv[10:5], lv[0]};
    assign {scan_start_in, rewrite_done_in, interp_data_take_in, term_rx_in, rx_rearm_in,
        tx_req_in, tx_done_in, tx_err_in, sr_start_in, sr_done_in, sr_fail_in} = ev;
    always #2 clk_in = ~clk_in;
    comm_port_status_flag_bank dut (.*);
    task automatic final_report(input bit to);
        if (to) error_cnt++;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer, released a cycle before the next can start
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1 && ++i < 20);
        if (i >= 20) final_report(1'b1);
        rdq = prdata_out;
        errq = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rdq, x)
    endtask
    // one-cycle event, then time for flags to settle
    task automatic pulse(input logic [23:0] v);
        ev <= v;
        @(posedge clk_in);
        ev <= '0;
        repeat (3) @(posedge clk_in);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        rd(CPS_ADDR_WORD_HI, {16'h0, CPS_HI_RST});
        for (int k = 0; k < 3; k++)
        begin
            lv <= rows[k][42:32];
            repeat (3) @(posedge clk_in);
            rd(CPS_ADDR_WORD_LO, {16'h0, rows[k][15:0]});
            rd(CPS_ADDR_WORD_HI, {16'h0, rows[k][31:16]});
        end
        lv <= 11'h001;
        apb(1'b1, CPS_ADDR_IRQ_MASK, 32'h100);
        pulse(24'h1c0fc0);
        `CHK(irq_out, 1'b1)
        rd(CPS_ADDR_WORD_LO, 32'hc384);
        rd(CPS_ADDR_WORD_HI, 32'h8795);
        pulse(24'h007000);
        rd(CPS_ADDR_WORD_LO, 32'h4104);
        rd(CPS_ADDR_WORD_HI, 32'h8515);
        apb(1'b1, CPS_ADDR_IRQ_STAT, 32'h100);
        @(posedge clk_in);
        `CHK(irq_out, 1'b0)
        pulse(24'h400000);
        pulse(24'h800000);
        rd(CPS_ADDR_WORD_LO, 32'h4114);
        pulse(24'h800000);
        rd(CPS_ADDR_WORD_LO, 32'h4104);
        pulse(24'h000030);
        rd(CPS_ADDR_WORD_HI, 32'h8105);
        {first_end_code_in, second_end_code_in, link_error_code_in} <= 48'h00a1_00b2_00c3;
        pulse(24'h00000d);
        rd(CPS_ADDR_WORD_HI, 32'h8535);
        rd(CPS_ADDR_ERR_CODE, 32'h00c3);
        rd(CPS_ADDR_END1, 32'h00a1);
        rd(CPS_ADDR_END2, 32'h00b2);
        apb(1'b1, CPS_ADDR_INTERP, 32'h1);
        rd(CPS_ADDR_WORD_HI, 32'h0535);
        apb(1'b1, CPS_ADDR_INTERP, 32'h2);
        `CHK(errq, 1'b1)
        pulse(24'h200000);
        `CHK(interp_load_out, 1'b0)
        apb(1'b1, CPS_ADDR_WORD_LO, 32'hffff_ffff);
        rd(CPS_ADDR_WORD_LO, 32'h4104);
        apb(1'b0, 8'h40, 32'h0);
        `CHK(errq, 1'b1)
        pulse(24'h078000);
        rd(CPS_ADDR_WORD_LO, 32'h0104);
        final_report(1'b0);
    end
endmodule
bind comm_port_status_flag_bank cps_bank_sva u_sva (.*);
`default_nettype wire

// ---- sim/cps_bank_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// port checks of the flag bank, one clock domain
module cps_bank_sva
import cps_pkg::*;
(
    input wire logic        clk_in, reset_in, psel_in, penable_in, pwrite_in,
    input wire logic        pready_out, pslverr_out, interp_load_out,
    input wire logic        print_busy_in, interp_busy_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic [3:0]  hsc_busy_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_acc; psel_in && penable_in && !pready_out; endsequence
    sequence s_lo; pready_out && !pwrite_in && paddr_in == CPS_ADDR_WORD_LO; endsequence
    sequence s_hi; pready_out && !pwrite_in && paddr_in == CPS_ADDR_WORD_HI; endsequence
    property p_ans; s_acc |=> pready_out; endproperty
    a_ans: assert property (p_ans) else $error("no answer after access");
    property p_pulse; pready_out |=> !pready_out; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_upper; s_lo |-> prdata_out[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("unused bits set");
    // levels must be steady long enough to reach the read data
    property p_print; s_lo ##0 ($stable(print_busy_in) && $past(print_busy_in, 2)
        == print_busy_in) |-> prdata_out[CPS_LO_PRINT] == print_busy_in; endproperty
    a_print: assert property (p_print) else $error("print flag wrong");
    property p_hsc; s_lo ##0 ($stable(hsc_busy_in) && $past(hsc_busy_in, 2) == hsc_busy_in)
        |-> prdata_out[CPS_LO_HSC0 +: CPS_NUM_HSC] == hsc_busy_in; endproperty
    a_hsc: assert property (p_hsc) else $error("counter flags wrong");
    property p_interp; s_hi ##0 ($stable(interp_busy_in) && $past(interp_busy_in, 2)
        == interp_busy_in) |-> prdata_out[CPS_HI_INTERP_ACT] == interp_busy_in; endproperty
    a_interp: assert property (p_interp) else $error("interp flag wrong");
    property p_refuse; pready_out && pwrite_in && paddr_in == CPS_ADDR_INTERP
        && $past(interp_load_out) && $past(interp_load_out, 2) |-> pslverr_out; endproperty
    a_refuse: assert property (p_refuse) else $error("early data accepted");
    property p_unmap; pready_out && paddr_in > CPS_ADDR_INTERP |-> pslverr_out; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
endmodule
`default_nettype wire
